// File: tb/dirf_checker.sv
// checker and bind for the record formatter
`default_nettype none
module dirf_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic req_valid,
    input wire dirf_pkg::dirf_req_s req,
    input wire logic req_ready,
    input wire logic refused,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire dirf_pkg::dirf_byte_s out_byte
);
    import dirf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic take, hs, ao, ht, pl;
    logic [4:0] ofs, hofs;
    logic [7:0] d;
    dirf_req_s pend, cur, rec;
    assign take = req_valid && req_ready && ce;
    assign hs = out_valid && out_ready && ce;
    assign d = out_byte.data;
    assign hofs = ofs - OFS_HART_ERR;
    assign rec = (ofs == 5'h00) ? pend : cur;
    assign ao = hs && rec.kind == KIND_AO_DIAG;
    assign ht = hs && rec.kind == KIND_HART_DIAG;
    assign pl = hs && rec.kind == KIND_PLUG_PULL;
    // pend follows requests, cur holds the record now leaving
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ofs <= 5'h00;
            pend <= '0;
            cur <= '0;
        end else begin
            if (take)
                pend <= req;
            if (hs && ofs == 5'h00)
                cur <= pend;
            if (hs)
                ofs <= out_byte.last ? 5'h00 : ofs + 5'h01;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    a_refuse_cause: assert property (take && req.kind == KIND_HW_INT && req.slot == TS_SLOT
        && !req.ts_record_ready |-> ##[1:2] refused) else $error("refused pulse missing");
    a_hart8_len: assert property (ht && ofs == OFS_LEN && rec.chan_count == HART_WIDE_CH
        |-> d == LEN_HART8) else $error("wide hart length wrong");
    a_ao_group: assert property (ao && ofs >= OFS_GROUP0 && ofs < OFS_ZERO_FIRST
        |-> d == rec.group_assign[ofs[1:0]]) else $error("group byte wrong");
    a_ao_zero: assert property (ao && ofs >= OFS_ZERO_FIRST |-> d == ZERO_BYTE)
        else $error("tail byte not zero");
    a_hart_type: assert property (ht && ofs == OFS_CH_TYPE
        |-> d == {rec.more_types, CH_TYPE_HART[6:0]}) else $error("channel type wrong");
    a_chan_count: assert property ((ao || ht) && ofs == OFS_CH_COUNT |-> d == {4'h0, rec.chan_count})
        else $error("channel count wrong");
    a_hart_pair: assert property (ht && ofs >= OFS_HART_ERR |-> d == (ofs[0] ?
        rec.hart_hi[hofs[3:1]] & 8'hdf : rec.hart_lo[hofs[3:1]])) else $error("error pair wrong");
    a_plug_type: assert property (pl && ofs == OFS_ITYPE
        |-> d == (rec.plugged ? ITYPE_PLUG : ITYPE_PULL)) else $error("plug type wrong");
    a_plug_id: assert property (pl && ofs >= OFS_MODID |-> d == (ofs == OFS_TYPE_HI ?
        rec.module_type[15:8] : ofs == OFS_TYPE_LO ? rec.module_type[7:0] : ZERO_BYTE)) else $error("id wrong");
    a_stall_hold: assert property (out_valid && !hs |=> out_valid && $stable(out_byte))
        else $error("stalled byte changed");
    c_refused: cover property (refused);
    c_wide_hart: cover property (ht && out_byte.last && rec.chan_count == HART_WIDE_CH);
    c_plug_end: cover property (pl && out_byte.last);
endmodule
bind dirf_formatter dirf_checker u_chk (.mclk(mclk), .rst(rst), .ce(ce), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .refused(refused), .out_valid(out_valid), .out_ready(out_ready), .out_byte(out_byte));
`default_nettype wire

// File: tb/dirf_sink.sv
// reading master model: collects bytes, may stall
`default_nettype none
module dirf_sink (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic stall,
    input wire logic clr,
    input wire logic out_valid,
    input wire dirf_pkg::dirf_byte_s out_byte,
    output logic out_ready,
    output logic [7:0] cnt,
    output logic done
);
    import dirf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:31];
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            out_ready <= 1'b0;
            cnt <= 8'h00;
            done <= 1'b0;
        end else begin
            out_ready <= stall ? !out_ready : 1'b1;
            if (clr) begin
                cnt <= 8'h00;
                done <= 1'b0;
            end else if (out_valid && out_ready && ce) begin
                mem[cnt[4:0]] <= out_byte.data;
                cnt <= cnt + 8'h01;
                done <= out_byte.last;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/test_diag_interrupt_record_formatter.sv
// testbench of the diagnostic interrupt record formatter
`default_nettype none
module test_diag_interrupt_record_formatter import dirf_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, rst, ce, req_valid, stall, clr, req_ready, refused, out_valid, out_ready, done;
    dirf_req_s req, r;
    dirf_byte_s out_byte;
    logic [7:0] cnt;
    int errors, n_tests;
    int cyc = 0;
    dirf_formatter u_dut (.mclk(mclk), .rst(rst), .ce(ce), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .refused(refused), .out_valid(out_valid), .out_ready(out_ready), .out_byte(out_byte));
    dirf_sink u_sink (.mclk(mclk), .rst(rst), .ce(ce), .stall(stall), .clr(clr), .out_valid(out_valid),
        .out_byte(out_byte), .out_ready(out_ready), .cnt(cnt), .done(done));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task stop_test;
        $display("errors %0d n_tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        ce <= (cyc % 8) != 5;
        if (cyc == 5000) begin
            errors++;
            stop_test();
        end
    end
    task chk8(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task send(input dirf_req_s q, input logic ex_ref);
        int k;
        logic saw;
        saw = 1'b0;
        k = 0;
        @(posedge mclk);
        clr <= 1'b1;
        req <= q;
        req_valid <= 1'b1;
        @(negedge mclk);
        while ((req_ready !== 1'b1 || ce !== 1'b1) && k < 50) begin
            @(negedge mclk);
            k++;
        end
        if (req_ready !== 1'b1 || ce !== 1'b1) begin
            errors++;
            $display("CHECK FAILED t=%0t request not taken", $time);
        end
        @(posedge mclk);
        req_valid <= 1'b0;
        clr <= 1'b0;
        repeat (3) begin
            @(negedge mclk);
            saw = saw | (refused === 1'b1);
        end
        k = 0;
        while (!ex_ref && done !== 1'b1 && k < 300) begin
            @(negedge mclk);
            k++;
        end
        if (!ex_ref && done !== 1'b1) begin
            errors++;
            $display("CHECK FAILED t=%0t record did not end", $time);
        end
        chk8({7'h00, saw}, {7'h00, ex_ref});
    endtask
    task t_ao;
        r = '0;
        r.kind = KIND_AO_DIAG;
        r.chan_count = 4'h4;
        r.ao_events = 4'h5;
        r.group_assign = {8'hd4, 8'hc3, 8'hb2, 8'ha1};
        send(r, 1'b0);
        chk8(cnt, 8'h14);
        chk8(u_sink.mem[10], 8'h04);
        chk8(u_sink.mem[11], 8'h05);
        chk8(u_sink.mem[14], 8'hc3);
        chk8(u_sink.mem[15], 8'hd4);
        for (int i = 16; i < 20; i++)
            chk8(u_sink.mem[i], 8'h00);
    endtask
    task t_hart(input logic [3:0] cc);
        r = '0;
        r.kind = KIND_HART_DIAG;
        r.chan_count = cc;
        r.more_types = 1'b1;
        r.hart_lo[0] = 8'h11;
        r.hart_hi[2] = 8'h81;
        r.hart_lo[7] = 8'h22;
        r.hart_hi[7] = 8'hff;
        @(posedge mclk);
        stall <= (cc == 4'h8);
        send(r, 1'b0);
        chk8(cnt, (cc == 4'h8) ? 8'h1c : 8'h14);
        chk8(u_sink.mem[8], 8'he5);
        chk8(u_sink.mem[9], 8'h10);
        chk8(u_sink.mem[10], {4'h0, cc});
        chk8(u_sink.mem[11], (cc == 4'h8) ? 8'h85 : 8'h05);
        chk8(u_sink.mem[12], 8'h11);
        chk8(u_sink.mem[17], 8'h81);
        if (cc == 4'h8) begin
            chk8(u_sink.mem[26], 8'h22);
            chk8(u_sink.mem[27], 8'hdf);
        end
    endtask
    task t_plug;
        for (int p = 0; p < 2; p++) begin
            r = '0;
            r.kind = KIND_PLUG_PULL;
            r.plugged = (p == 1);
            r.module_type = 16'hbeef;
            send(r, 1'b0);
            chk8(cnt, 8'h09);
            chk8(u_sink.mem[1], (p == 1) ? 8'h03 : 8'h04);
            for (int i = 4; i < 7; i++)
                chk8(u_sink.mem[i], 8'h00);
            chk8(u_sink.mem[7], 8'hbe);
            chk8(u_sink.mem[8], 8'hef);
        end
    endtask
    task t_hw;
        r = '0;
        r.kind = KIND_HW_INT;
        r.slot = TS_SLOT;
        send(r, 1'b1);
        chk8(cnt, 8'h00);
        r.ts_record_ready = 1'b1;
        send(r, 1'b0);
        chk8(cnt, 8'h04);
        chk8(u_sink.mem[2], 8'h02);
    endtask
    initial begin
        rst = 1'b1;
        ce = 1'b1;
        req_valid = 1'b0;
        req = '0;
        stall = 1'b0;
        clr = 1'b0;
        errors = 0;
        n_tests = 0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        t_ao();
        t_hart(4'h4);
        t_hart(4'h8);
        t_plug();
        t_hw();
        stop_test();
    end
endmodule
`default_nettype wire

// File: verilog/dirf_formatter.sv
// formatter that streams one interrupt section of the slave diagnostic record per request
//
// What this block does
// [R1] Analog-output records carry group assignment bytes for groups two and three in the group zero layout.
// [R2] Analog-output records drive offsets sixteen to nineteen to zero.
// [R3] A hart module with eight channels gets channels four to seven appended, up to offset twenty-seven.
// [R4] The hart channel-type byte holds code 65 hex, with a flag bit telling whether another channel type follows.
// [R5] The hart length byte after the channel-type byte reports sixteen bits per channel.
// [R6] The byte after the length byte holds the module's channel count.
// [R7] The channel error vector has bit n set when channel n has an active diagnostic event.
// [R8] Each hart channel's error type takes two bytes, channel zero first, the rest in order.
// [R9] The upper hart error byte flags limit violations, current saturation, further status, config change and fault.
// [R10] A hardware interrupt in slot two goes out only when a time-stamp or special-message record is ready.
// [R11] A plug/pull record encodes in the interrupt type byte whether the module was plugged or pulled.
// [R12] A plug/pull record fills five bytes from offset four with the module identifier.
// [R13] The type identification high byte sits at offset seven, the low byte at eight.
// [R14] The three identifier bytes without meaning are driven to zero.
`default_nettype none
module dirf_formatter (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic req_valid,
    input wire dirf_pkg::dirf_req_s req,
    output logic req_ready,
    output logic refused,
    output logic out_valid,
    input wire logic out_ready,
    output dirf_pkg::dirf_byte_s out_byte
);
    import dirf_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SEND = 2'b01,
        ST_DONE = 2'b10
    } dirf_state_e;

    dirf_state_e state;
    dirf_state_e next_state;
    dirf_req_s held;
    dirf_req_s next_held;
    logic [4:0] offs;
    logic [4:0] next_offs;
    logic [4:0] rec_len;
    logic [4:0] next_rec_len;
    logic next_req_ready;
    logic next_refused;

    logic [CH_MAX-1:0] hart_vec;
    logic [7:0] cur_data;
    logic [4:0] len_for_req;
    logic take;
    logic buf_in_ready;
    dirf_byte_s buf_in;
    logic [2:0] hart_ch;
    logic [2:0] group_idx;
    logic [4:0] rel;

    // per channel event flag for the hart error vector
    generate
        for (genvar i = 0; i < CH_MAX; i++) begin : g_vec
            assign hart_vec[i] = ((held.hart_lo[i] != ZERO_BYTE) || (held.hart_hi[i] != ZERO_BYTE))
                && (4'(i) < held.chan_count); // R7
        end
    endgenerate

    // record length of an incoming request
    always_comb begin
        case (req.kind)
            KIND_AO_DIAG: len_for_req = LEN_AO;
            KIND_HART_DIAG: len_for_req = (req.chan_count == HART_WIDE_CH) ? LEN_HART8 : LEN_HART4; // R3
            KIND_HW_INT: len_for_req = LEN_HW;
            KIND_PLUG_PULL: len_for_req = LEN_PLUG;
            default: len_for_req = LEN_HW;
        endcase
    end

    // byte value at the current offset
    always_comb begin
        rel = offs - OFS_HART_ERR;
        hart_ch = rel[3:1];
        group_idx = 3'(offs - OFS_GROUP0);
        cur_data = ZERO_BYTE;
        if (offs == OFS_LEN) begin
            cur_data = {3'h0, rec_len};
        end else if (offs == OFS_ITYPE) begin
            case (held.kind)
                KIND_HW_INT: cur_data = ITYPE_HW;
                KIND_PLUG_PULL: cur_data = held.plugged ? ITYPE_PLUG : ITYPE_PULL; // R11
                default: cur_data = ITYPE_DIAG;
            endcase
        end else if (offs == OFS_SLOT) begin
            cur_data = held.slot;
        end else if (offs == OFS_SPEC) begin
            cur_data = held.spec;
        end else begin
            case (held.kind)
                KIND_AO_DIAG: begin
                    if (offs == OFS_CH_TYPE) begin
                        cur_data = held.ao_chan_type;
                    end else if (offs == OFS_DIAG_LEN) begin
                        cur_data = DIAG_LEN_AO;
                    end else if (offs == OFS_CH_COUNT) begin
                        cur_data = {4'h0, held.chan_count}; // R6
                    end else if (offs == OFS_ERR_VEC) begin
                        cur_data = {4'h0, held.ao_events}; // R7
                    end else if (offs >= OFS_GROUP0 && offs < OFS_ZERO_FIRST) begin
                        cur_data = held.group_assign[group_idx[1:0]]; // R1
                    end else begin
                        cur_data = ZERO_BYTE; // R2
                    end
                end
                KIND_HART_DIAG: begin
                    if (offs == OFS_CH_TYPE) begin
                        cur_data = CH_TYPE_HART; // R4
                        cur_data[HART_MORE_BIT] = held.more_types; // R4
                    end else if (offs == OFS_DIAG_LEN) begin
                        cur_data = DIAG_LEN_HART; // R5
                    end else if (offs == OFS_CH_COUNT) begin
                        cur_data = {4'h0, held.chan_count}; // R6
                    end else if (offs == OFS_ERR_VEC) begin
                        cur_data = hart_vec; // R7
                    end else if (rel[0] == 1'b0) begin
                        cur_data = held.hart_lo[hart_ch]; // R8
                    end else begin
                        cur_data = held.hart_hi[hart_ch]; // R9
                        cur_data[5] = 1'b0;
                    end
                end
                KIND_PLUG_PULL: begin
                    if (offs == OFS_TYPE_HI) begin
                        cur_data = held.module_type[15:8]; // R13
                    end else if (offs == OFS_TYPE_LO) begin
                        cur_data = held.module_type[7:0]; // R13
                    end else if (offs >= OFS_MODID) begin
                        cur_data = ZERO_BYTE; // R14
                    end
                end
                default: cur_data = ZERO_BYTE;
            endcase
        end
        buf_in.data = cur_data; // R12
        buf_in.last = (offs == rec_len - 5'h1);
    end

    // sequencing of requests and bytes
    always_comb begin
        next_state = state;
        next_held = held;
        next_offs = offs;
        next_rec_len = rec_len;
        next_refused = 1'b0;
        take = 1'b0;
        case (state)
            ST_IDLE: begin
                if (req_valid && req_ready) begin
                    if (req.kind == KIND_HW_INT && req.slot == TS_SLOT && !req.ts_record_ready) begin
                        next_refused = 1'b1; // R10
                        next_state = ST_DONE;
                    end else begin
                        next_held = req;
                        next_offs = OFS_LEN;
                        next_rec_len = len_for_req;
                        next_state = ST_SEND;
                    end
                end
            end
            ST_SEND: begin
                if (buf_in_ready) begin
                    take = 1'b1;
                    next_offs = offs + 5'h1;
                    if (buf_in.last) begin
                        next_state = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        next_req_ready = (next_state == ST_IDLE);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            held <= '0;
            offs <= OFS_LEN;
            rec_len <= LEN_HW;
            req_ready <= 1'b0;
            refused <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            held <= next_held;
            offs <= next_offs;
            rec_len <= next_rec_len;
            req_ready <= next_req_ready;
            refused <= next_refused;
        end
    end

    dirf_skid_buf #(
        .WIDTH($bits(dirf_byte_s))
    ) u_buf (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .in_valid(take),
        .in_ready(buf_in_ready),
        .in_data(buf_in),
        .out_valid(out_valid),
        .out_ready(out_ready),
        .out_data(out_byte)
    );
endmodule
`default_nettype wire

// File: verilog/dirf_pkg.sv
// shared constants and carrier types of the diagnostic interrupt record formatter
`default_nettype none
package dirf_pkg;
    localparam int CH_MAX = 8;
    localparam int GROUPS = 4;
    // byte offsets within the record
    localparam logic [4:0] OFS_LEN = 5'h00;
    localparam logic [4:0] OFS_ITYPE = 5'h01;
    localparam logic [4:0] OFS_SLOT = 5'h02;
    localparam logic [4:0] OFS_SPEC = 5'h03;
    localparam logic [4:0] OFS_MODID = 5'h04;
    localparam logic [4:0] OFS_TYPE_HI = 5'h07;
    localparam logic [4:0] OFS_TYPE_LO = 5'h08;
    localparam logic [4:0] OFS_CH_TYPE = 5'h08;
    localparam logic [4:0] OFS_DIAG_LEN = 5'h09;
    localparam logic [4:0] OFS_CH_COUNT = 5'h0a;
    localparam logic [4:0] OFS_ERR_VEC = 5'h0b;
    localparam logic [4:0] OFS_GROUP0 = 5'h0c;
    localparam logic [4:0] OFS_ZERO_FIRST = 5'h10;
    localparam logic [4:0] OFS_HART_ERR = 5'h0c;
    // record lengths in bytes
    localparam logic [4:0] LEN_AO = 5'h14;
    localparam logic [4:0] LEN_HART4 = 5'h14;
    localparam logic [4:0] LEN_HART8 = 5'h1c;
    localparam logic [4:0] LEN_HW = 5'h04;
    localparam logic [4:0] LEN_PLUG = 5'h09;
    // byte codes
    localparam logic [7:0] CH_TYPE_HART = 8'h65;
    localparam int HART_MORE_BIT = 7;
    localparam logic [7:0] DIAG_LEN_AO = 8'h08;
    localparam logic [7:0] DIAG_LEN_HART = 8'h10;
    localparam logic [7:0] ITYPE_DIAG = 8'h01;
    localparam logic [7:0] ITYPE_HW = 8'h02;
    localparam logic [7:0] ITYPE_PLUG = 8'h03;
    localparam logic [7:0] ITYPE_PULL = 8'h04;
    localparam logic [7:0] TS_SLOT = 8'h02;
    localparam logic [3:0] HART_WIDE_CH = 4'h8;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    typedef enum logic [1:0] {
        KIND_AO_DIAG = 2'b00,
        KIND_HART_DIAG = 2'b01,
        KIND_HW_INT = 2'b10,
        KIND_PLUG_PULL = 2'b11
    } dirf_kind_e;

    // upper error byte of a hart channel, bit 15 down to bit 8
    typedef struct packed {
        logic field_fault;
        logic cfg_changed;
        logic rsvd;
        logic more_status;
        logic ao_saturated;
        logic ao_fixed;
        logic sv_out_of_limits;
        logic pv_out_of_limits;
    } dirf_hart_hi_s;

    typedef struct packed {
        dirf_kind_e kind;
        logic [7:0] slot;
        logic [7:0] spec;
        logic plugged;
        logic more_types;
        logic [3:0] chan_count;
        logic [7:0] ao_chan_type;
        logic [GROUPS-1:0] ao_events;
        logic [GROUPS-1:0][7:0] group_assign;
        logic [CH_MAX-1:0][7:0] hart_lo;
        dirf_hart_hi_s [CH_MAX-1:0] hart_hi;
        logic [15:0] module_type;
        logic ts_record_ready;
    } dirf_req_s;

    typedef struct packed {
        logic last;
        logic [7:0] data;
    } dirf_byte_s;
endpackage
`default_nettype wire

// File: verilog/dirf_skid_buf.sv
// two-entry buffer with valid and ready on both sides
`default_nettype none
module dirf_skid_buf #(
    parameter int WIDTH = 9
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    // output entry and overflow entry, both registered
    logic [WIDTH-1:0] main_data;
    logic main_valid;
    logic [WIDTH-1:0] skid_data;
    logic skid_valid;
    logic [WIDTH-1:0] next_main_data;
    logic next_main_valid;
    logic [WIDTH-1:0] next_skid_data;
    logic next_skid_valid;
    logic push;
    logic drain;

    assign in_ready = !skid_valid;
    assign out_valid = main_valid;
    assign out_data = main_data;

    always_comb begin
        push = in_valid && !skid_valid;
        drain = !main_valid || out_ready;
        next_main_data = main_data;
        next_main_valid = main_valid;
        next_skid_data = skid_data;
        next_skid_valid = skid_valid;
        if (drain) begin
            if (skid_valid) begin
                next_main_data = skid_data;
                next_main_valid = 1'b1;
                next_skid_valid = 1'b0;
            end else begin
                next_main_data = push ? in_data : main_data;
                next_main_valid = push;
            end
        end else if (push) begin
            next_skid_data = in_data;
            next_skid_valid = 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            main_data <= '0;
            main_valid <= 1'b0;
            skid_data <= '0;
            skid_valid <= 1'b0;
        end else if (ce) begin
            main_data <= next_main_data;
            main_valid <= next_main_valid;
            skid_data <= next_skid_data;
            skid_valid <= next_skid_valid;
        end
    end
endmodule
`default_nettype wire
